//--- dv/descriptor_server_props.sv
`timescale 1ns/1ps
// protocol checks on the setup and byte stream ports
module descriptor_server_props (
	input wire        ref_clk_i,
	input wire        arst_n_i,
	input wire        setup_valid_i,
	input wire [7:0]  setup_type_i,
	input wire [7:0]  setup_request_i,
	input wire [15:0] setup_value_i,
	input wire [15:0] setup_length_i,
	input wire        tx_ready_i,
	input wire        busy_o,
	input wire        tx_valid_o,
	input wire [7:0]  tx_data_o,
	input wire        tx_last_o,
	input wire        done_o,
	input wire        stall_o,
	input wire        configured_o,
	input wire        alt_setting_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// request taken and get-descriptor decode
	wire take  = setup_valid_i && !busy_o;
	wire get_d = take && setup_type_i == 8'h80 && setup_request_i == 8'h06;

	data_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
		&& $stable(tx_last_o)) else $error("byte changed while stalled");
	last_done_a: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> done_o && !tx_valid_o)
		else $error("no completion after last byte");
	one_outcome_a: assert property (done_o |-> !stall_o && !tx_valid_o && !busy_o)
		else $error("completion overlaps other outcome");
	dev_first_a: assert property (get_d && setup_value_i == 16'h0100 && setup_length_i != 0
		|=> tx_valid_o && busy_o && tx_data_o == 8'h12) else $error("device length byte wrong");
	qual_first_a: assert property (get_d && setup_value_i == 16'h0600 && setup_length_i != 0
		|=> tx_valid_o && tx_data_o == 8'h0a) else $error("qualifier length byte wrong");
	cfg_first_a: assert property (get_d && setup_value_i == 16'h0200 && setup_length_i != 0
		|=> tx_valid_o && tx_data_o == 8'h09) else $error("configuration length byte wrong");
	one_byte_a: assert property (get_d && setup_value_i == 16'h0100 && setup_length_i == 16'h0001
		|=> tx_last_o) else $error("one byte request not ended");
	zero_len_a: assert property (get_d && setup_value_i == 16'h0100 && setup_length_i == 16'h0000
		|=> done_o && !tx_valid_o) else $error("zero length request sent data");
	set_cfg_a: assert property (take && setup_type_i == 8'h00 && setup_request_i == 8'h09
		&& setup_value_i == 16'h0001 |=> configured_o && done_o && !alt_setting_o)
		else $error("configuration not selected");
	ifc_stall_a: assert property (take && !configured_o && (setup_request_i == 8'h0a
		|| setup_request_i == 8'h0b) |=> stall_o) else $error("interface request not refused");
	// main scenarios
	cover property (tx_valid_o && !tx_ready_i);
	cover property (tx_last_o && tx_ready_i);
	cover property (stall_o);
	cover property ($rose(configured_o));
endmodule

//--- dv/host_model.sv
`timescale 1ns/1ps
// host side: issues setup packets and takes data bytes
module host_model (
	input  wire        ref_clk_i,
	input  wire        arst_n_i,
	input  wire        slow_i,
	output reg         setup_valid_o,
	output reg  [7:0]  setup_type_o,
	output reg  [7:0]  setup_request_o,
	output reg  [15:0] setup_value_o,
	output reg  [15:0] setup_index_o,
	output reg  [15:0] setup_length_o,
	output reg         tx_ready_o
);
	integer    seed = 32'h931549cf;
	reg [31:0] rnd;
	initial begin
		{setup_valid_o, setup_type_o, setup_request_o} <= 17'h0;
		{setup_value_o, setup_index_o, setup_length_o} <= 48'h0;
	end
	// takes every byte at once, or stalls at random when slow
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		rnd = $random(seed);
		if (!arst_n_i)
			tx_ready_o <= 1'b0;
		else
			tx_ready_o <= slow_i ? rnd[0] : 1'b1;
	end
	// one-cycle setup strobe; type and value fields scrambled once it drops
	task send(input [7:0] t, input [7:0] r, input [15:0] v, input [15:0] ix, input [15:0] l);
		@(posedge ref_clk_i);
		setup_valid_o <= 1'b1;
		{setup_type_o, setup_request_o} <= {t, r};
		{setup_value_o, setup_index_o, setup_length_o} <= {v, ix, l};
		@(posedge ref_clk_i);
		setup_valid_o <= 1'b0;
		{setup_type_o, setup_value_o} <= {~t, ~v};
	endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
	localparam [15:0] VID = 16'h1234; // arbitrary value
	localparam [15:0] PID = 16'h5678; // arbitrary value
	localparam [15:0] REL = 16'h0102;
	// endpoint body bytes count up from 01, one per stored byte
	localparam [239:0] EPB = 240'h1e1d1c1b1a191817161514131211100f0e0d0c0b0a090807060504030201;
	reg         ref_clk_i = 1'b0;
	reg         arst_n_i  = 1'b0;
	reg         slow      = 1'b0;
	wire        setup_valid_i, tx_ready_i, busy_o, tx_valid_o, tx_last_o;
	wire        done_o, stall_o, configured_o, alt_setting_o;
	wire [7:0]  setup_type_i, setup_request_i, tx_data_o;
	wire [15:0] setup_value_i, setup_index_i, setup_length_i;
	integer     n_fail = 0;
	integer     n_tests = 0;
	integer     cyc = 0;
	reg [8:0]   exp_q [$];
	reg [143:0] dev_v;
	reg [79:0]  qual_v;
	reg [215:0] cfg_v;

	default_descriptor_server #(.VENDOR_ID(VID), .PRODUCT_ID(PID), .RELEASE_BCD(REL), .EP_BODY(EPB))
		u_default_descriptor_server (.*);
	host_model u_host_model (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .slow_i(slow),
		.setup_valid_o(setup_valid_i), .setup_type_o(setup_type_i), .setup_request_o(setup_request_i),
		.setup_value_o(setup_value_i), .setup_index_o(setup_index_i), .setup_length_o(setup_length_i),
		.tx_ready_o(tx_ready_i));

	always #2 ref_clk_i = ~ref_clk_i;

	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input [8*12-1:0] what, input [8:0] e, input [8:0] s);
		n_tests = n_tests + 1;
		if (s !== e) begin
			n_fail = n_fail + 1;
			$display("unexpected %0s expected %h seen %h", what, e, s);
		end
	endtask

	// expected byte at an offset of a stored descriptor
	function [7:0] exp_b(input [1:0] k, input [7:0] o);
		if (k == 2'h0)
			exp_b = dev_v[8*(17-o) +: 8];
		else if (k == 2'h1)
			exp_b = qual_v[8*(9-o) +: 8];
		else if (o < 27)
			exp_b = cfg_v[8*(26-o) +: 8];
		else
			exp_b = (o - 27) % 7 == 0 ? 8'h07 : (o - 27) % 7 == 1 ? 8'h05 : (o - 27) / 7 * 5 + (o - 27) % 7 - 1;
	endfunction

	// one request; waits for its outcome, bounded
	task req(input [7:0] t, input [7:0] r, input [15:0] v, input [15:0] l, input st);
		integer k;
		k = 0;
		u_host_model.send(t, r, v, 16'h0000, l);
		do begin
			@(posedge ref_clk_i);
			k = k + 1;
		end while (done_o !== 1'b1 && stall_o !== 1'b1 && k < 400);
		chk("outcome", {7'h0, ~st, st}, {7'h0, done_o, stall_o});
		chk("left bytes", 9'h0, exp_q.size());
	endtask

	// notes the expected stream, then asks for the descriptor
	task get(input [1:0] k, input [15:0] l);
		integer n, i;
		n = k == 2'h0 ? 18 : k == 2'h1 ? 10 : 69;
		if (l < n)
			n = l;
		for (i = 0; i < n; i = i + 1)
			exp_q.push_back({i == n - 1, exp_b(k, i[7:0])});
		req(8'h80, 8'h06, k == 2'h0 ? 16'h0100 : k == 2'h1 ? 16'h0600 : 16'h0200, l, 1'b0);
	endtask

	// compares each taken byte with the oldest note
	always @(posedge ref_clk_i) begin
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
			chk("tx byte", exp_q.size() ? exp_q.pop_front() : 9'h1ff, {tx_last_o, tx_data_o});
	end

	// cuts a hang short
	always @(posedge ref_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			finish_test;
		end
	end

	initial begin
		dev_v  = {64'h12010002ffffff40, VID[7:0], VID[15:8], PID[7:0], PID[15:8], REL[7:0], REL[15:8], 32'h00000001};
		qual_v = 80'h0a060002ffffff400100;
		cfg_v  = 216'h0902ab0001010080320904000000ffffff000904000106ffffff00;
		repeat (4) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		get(2'h0, 16'd18);
		get(2'h0, 16'd64);
		get(2'h0, 16'd1);
		get(2'h0, 16'd0);
		get(2'h1, 16'd10);
		get(2'h1, 16'd255);
		get(2'h2, 16'd9);
		slow <= 1'b1;
		get(2'h2, 16'd171);
		slow <= 1'b0;
		req(8'h80, 8'h06, 16'h0300, 16'd8, 1'b1);
		req(8'h80, 8'h06, 16'h0700, 16'd8, 1'b1);
		req(8'h80, 8'h06, 16'h0101, 16'd8, 1'b1);
		req(8'h81, 8'h0a, 16'h0000, 16'd1, 1'b1);
		req(8'h00, 8'h09, 16'h0002, 16'd0, 1'b1);
		req(8'h00, 8'h09, 16'h0001, 16'd0, 1'b0);
		chk("config", 9'h100, {configured_o, 8'h00});
		exp_q.push_back(9'h101);
		req(8'h80, 8'h08, 16'h0000, 16'd1, 1'b0);
		req(8'h01, 8'h0b, 16'h0001, 16'd0, 1'b0);
		chk("alt", 9'h001, {8'h00, alt_setting_o});
		exp_q.push_back(9'h101);
		req(8'h81, 8'h0a, 16'h0000, 16'd1, 1'b0);
		req(8'h01, 8'h0b, 16'h0002, 16'd0, 1'b1);
		req(8'h00, 8'h09, 16'h0001, 16'd0, 1'b0);
		chk("alt", 9'h000, {8'h00, alt_setting_o});
		req(8'h00, 8'h09, 16'h0000, 16'd0, 1'b0);
		chk("config", 9'h000, {configured_o, 8'h00});
		exp_q.push_back(9'h100);
		req(8'h80, 8'h08, 16'h0000, 16'd1, 1'b0);
		req(8'h01, 8'h0b, 16'h0001, 16'd0, 1'b1);
		finish_test;
	end
endmodule

bind default_descriptor_server descriptor_server_props u_descriptor_server_props (.*);

//--- logic/default_descriptor_server.v
// How it works
// - device descriptor is 18 bytes, length then device type code
// - device descriptor reports release 2.00, low byte first
// - device class, subclass and protocol read vendor-specific
// - endpoint zero packet size is 64 bytes
// - vendor then product identifier, each low byte first
// - release number, low byte first, set by part variant
// - all three string index bytes are zero
// - last device byte reports one configuration
// - get-descriptor for device returns the device descriptor
// - bytes go out in ascending offset order, exactly as stored
// - qualifier is 10 bytes, type 06, release and class as device
// - qualifier gives 64-byte packet, one configuration, zero reserved
// - configuration header is 9 bytes, type 02, one interface
// - configuration total length reads 171, low byte first
// - configuration value is 1; host selects it by set-configuration
// - bus powered, no wakeup, 100 mA, no string
// - alternate 0 interface: 9 bytes, type 04, no endpoints, vendor class
// - alternate 1 interface: setting 1, six endpoints, vendor class
// - each endpoint descriptor is 7 bytes with type 05
`timescale 1ns/1ps
`include "descriptor_defines.vh"

module default_descriptor_server #(
	parameter [15:0]  VENDOR_ID   = 16'h1234, // arbitrary value
	parameter [15:0]  PRODUCT_ID  = 16'h5678, // arbitrary value
	parameter [15:0]  RELEASE_BCD = 16'h0000,
	parameter [239:0] EP_BODY     = 240'h0
) (
	input  wire        ref_clk_i,
	input  wire        arst_n_i,
	input  wire        setup_valid_i,
	input  wire [7:0]  setup_type_i,
	input  wire [7:0]  setup_request_i,
	input  wire [15:0] setup_value_i,
	input  wire [15:0] setup_index_i,
	input  wire [15:0] setup_length_i,
	input  wire        tx_ready_i,
	output wire        busy_o,
	output wire        tx_valid_o,
	output wire [7:0]  tx_data_o,
	output wire        tx_last_o,
	output wire        done_o,
	output wire        stall_o,
	output wire        configured_o,
	output wire        alt_setting_o
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_SEND = 2'b10;

	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg  [1:0]  kind_q;
	reg  [1:0]  kind_d;
	reg  [7:0]  idx_q;
	reg  [7:0]  idx_d;
	reg  [7:0]  last_idx_q;
	reg  [7:0]  last_idx_d;
	reg  [7:0]  reply_q;
	reg  [7:0]  reply_d;
	reg         valid_q;
	reg         valid_d;
	reg  [7:0]  data_q;
	reg  [7:0]  data_d;
	reg         last_q;
	reg         last_d;
	reg         done_q;
	reg         done_d;
	reg         stall_q;
	reg         stall_d;
	reg         cfg_q;
	reg         cfg_d;
	reg         alt_q;
	reg         alt_d;
	reg         busy_q;
	reg         busy_d;
	reg  [1:0]  rom_kind;
	reg  [7:0]  rom_idx;
	wire [7:0]  rom_byte;
	reg  [7:0]  size;
	reg         want_data;
	reg  [15:0] send_len;

	// shorter of requested length and stored size
	function [15:0] clip_len;
		input [15:0] want;
		input [7:0]  have;
		begin
			if (want < {8'h00, have}) begin
				clip_len = want;
			end else begin
				clip_len = {8'h00, have};
			end
		end
	endfunction

	// true when a setup packet matches type and request code
	function is_req;
		input [7:0] rtype;
		input [7:0] rcode;
		input [7:0] want_type;
		input [7:0] want_code;
		begin
			is_req = (rtype == want_type) && (rcode == want_code);
		end
	endfunction

	// rom source select for a requested descriptor type
	// unknown types fall back to the device source, their byte is never sent
	function [1:0] kind_of;
		input [7:0] dtype;
		begin
			case (dtype)
			`DT_DEVICE:    kind_of = `KIND_DEVICE;
			`DT_QUALIFIER: kind_of = `KIND_QUALIFIER;
			`DT_CONFIG:    kind_of = `KIND_CONFIG;
			default:       kind_of = `KIND_DEVICE;
			endcase
		end
	endfunction

	descriptor_rom #(
		.VENDOR_ID   (VENDOR_ID),
		.PRODUCT_ID  (PRODUCT_ID),
		.RELEASE_BCD (RELEASE_BCD),
		.EP_BODY     (EP_BODY)
	) u_rom (
		.kind_i (rom_kind),
		.idx_i  (rom_idx),
		.byte_o (rom_byte)
	);

	// request decode and byte sequencing
	always @* begin
		state_d    = state_q;
		kind_d     = kind_q;
		idx_d      = idx_q;
		last_idx_d = last_idx_q;
		reply_d    = reply_q;
		valid_d    = valid_q;
		data_d     = data_q;
		last_d     = last_q;
		done_d     = 1'b0;
		stall_d    = 1'b0;
		cfg_d      = cfg_q;
		alt_d      = alt_q;
		busy_d     = busy_q;
		size       = 8'h00;
		want_data  = 1'b0;
		send_len   = 16'h0000;
		case (state_q)
		ST_IDLE: begin
			if (setup_valid_i) begin
				if (is_req(setup_type_i, setup_request_i, `RT_DEV_IN, `RQ_GET_DESCRIPTOR)
					&& setup_value_i[7:0] == 8'h00) begin
					want_data = 1'b1;
					case (setup_value_i[15:8])
					`DT_DEVICE: begin
						kind_d = `KIND_DEVICE;
						size   = `LEN_DEVICE;
					end
					`DT_QUALIFIER: begin
						kind_d = `KIND_QUALIFIER;
						size   = `LEN_QUALIFIER;
					end
					`DT_CONFIG: begin
						kind_d = `KIND_CONFIG;
						size   = `CFG_STORED_LEN;
					end
					default: begin
						want_data = 1'b0;
						stall_d   = 1'b1;
					end
					endcase
				end else if (is_req(setup_type_i, setup_request_i, `RT_DEV_IN, `RQ_GET_CONFIG)) begin
					want_data = 1'b1;
					kind_d    = `KIND_REPLY;
					size      = 8'h01;
					reply_d   = cfg_q ? `CFG_VALUE : 8'h00;
				end else if (is_req(setup_type_i, setup_request_i, `RT_DEV_OUT, `RQ_SET_CONFIG)) begin
					// only value 1 selects the configuration, 0 clears it
					if (setup_value_i == {8'h00, `CFG_VALUE}) begin
						cfg_d  = 1'b1;
						alt_d  = 1'b0;
						done_d = 1'b1;
					end else if (setup_value_i == 16'h0000) begin
						cfg_d  = 1'b0;
						alt_d  = 1'b0;
						done_d = 1'b1;
					end else begin
						stall_d = 1'b1;
					end
				end else if (is_req(setup_type_i, setup_request_i, `RT_IF_IN, `RQ_GET_INTERFACE)
					&& cfg_q && setup_index_i == 16'h0000) begin
					want_data = 1'b1;
					kind_d    = `KIND_REPLY;
					size      = 8'h01;
					reply_d   = {7'h00, alt_q};
				end else if (is_req(setup_type_i, setup_request_i, `RT_IF_OUT, `RQ_SET_INTERFACE)
					&& cfg_q && setup_index_i == 16'h0000 && setup_value_i < 16'h0002) begin
					alt_d  = setup_value_i[0];
					done_d = 1'b1;
				end else begin
					stall_d = 1'b1;
				end
				if (want_data) begin
					send_len = clip_len(setup_length_i, size);
					if (send_len == 16'h0000) begin
						done_d = 1'b1;
					end else begin
						// first byte fetched straight from the new source
						idx_d      = 8'h00;
						last_idx_d = send_len[7:0] - 8'h01;
						data_d     = (kind_d == `KIND_REPLY) ? reply_d : rom_byte;
						last_d     = (send_len == 16'h0001);
						valid_d    = 1'b1;
						busy_d     = 1'b1;
						state_d    = ST_SEND;
					end
				end
			end
		end
		ST_SEND: begin
			if (tx_ready_i) begin
				if (last_q) begin
					valid_d = 1'b0;
					last_d  = 1'b0;
					done_d  = 1'b1;
					busy_d  = 1'b0;
					state_d = ST_IDLE;
				end else begin
					// next offset in ascending order
					idx_d   = idx_q + 8'h01;
					data_d  = (kind_q == `KIND_REPLY) ? reply_q : rom_byte;
					last_d  = (idx_d == last_idx_q);
				end
			end
		end
		default: begin
			state_d = ST_IDLE;
			valid_d = 1'b0;
			last_d  = 1'b0;
			busy_d  = 1'b0;
		end
		endcase
	end

	// rom address: offset 0 of the requested source while idle,
	// the next offset while sending, so each fetch costs no cycle
	always @* begin
		rom_kind = kind_q;
		rom_idx  = idx_q + 8'h01;
		if (state_q != ST_SEND) begin
			rom_kind = kind_of(setup_value_i[15:8]);
			rom_idx  = 8'h00;
		end
	end

	// state flops
	always @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q    <= ST_IDLE;
			kind_q     <= `KIND_DEVICE;
			idx_q      <= 8'h00;
			last_idx_q <= 8'h00;
			reply_q    <= 8'h00;
			valid_q    <= 1'b0;
			data_q     <= 8'h00;
			last_q     <= 1'b0;
			done_q     <= 1'b0;
			stall_q    <= 1'b0;
			cfg_q      <= 1'b0;
			alt_q      <= 1'b0;
			busy_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			kind_q     <= kind_d;
			idx_q      <= idx_d;
			last_idx_q <= last_idx_d;
			reply_q    <= reply_d;
			valid_q    <= valid_d;
			data_q     <= data_d;
			last_q     <= last_d;
			done_q     <= done_d;
			stall_q    <= stall_d;
			cfg_q      <= cfg_d;
			alt_q      <= alt_d;
			busy_q     <= busy_d;
		end
	end

	// outputs straight from flops
	assign busy_o        = busy_q;
	assign tx_valid_o    = valid_q;
	assign tx_data_o     = data_q;
	assign tx_last_o     = last_q;
	assign done_o        = done_q;
	assign stall_o       = stall_q;
	assign configured_o  = cfg_q;
	assign alt_setting_o = alt_q;

endmodule

//--- logic/descriptor_defines.vh
`ifndef DESCRIPTOR_DEFINES_VH
`define DESCRIPTOR_DEFINES_VH

// descriptor type codes
`define DT_DEVICE           8'h01
`define DT_CONFIG           8'h02
`define DT_INTERFACE        8'h04
`define DT_ENDPOINT         8'h05
`define DT_QUALIFIER        8'h06

// descriptor lengths
`define LEN_DEVICE          8'h12
`define LEN_QUALIFIER       8'h0a
`define LEN_CONFIG          8'h09
`define LEN_INTERFACE       8'h09
`define LEN_ENDPOINT        8'h07

// field values
`define SPEC_REL_LO         8'h00
`define SPEC_REL_HI         8'h02
`define CLASS_VENDOR        8'hff
`define EP0_MAX_PKT         8'h40
`define NO_STRING           8'h00
`define NUM_CONFIGS         8'h01
`define QUAL_RESERVED       8'h00
`define CFG_TOTAL_LO        8'hab
`define CFG_TOTAL_HI        8'h00
`define CFG_NUM_IFACES      8'h01
`define CFG_VALUE           8'h01
`define CFG_ATTR_BUS_PWR    8'h80
`define CFG_MAX_POWER       8'h32
`define IFACE_NUMBER        8'h00
`define ALT0_SETTING        8'h00
`define ALT0_NUM_EP         8'h00
`define ALT1_SETTING        8'h01
`define ALT1_NUM_EP         8'h06

// byte layout of the stored configuration set
`define CFG_ALT0_BASE       8'h09
`define CFG_ALT1_BASE       8'h12
`define CFG_EP_BASE         8'h1b
`define CFG_STORED_LEN      8'h45

// source selects of the byte server
`define KIND_DEVICE         2'h0
`define KIND_QUALIFIER      2'h1
`define KIND_CONFIG         2'h2
`define KIND_REPLY          2'h3

// standard request codes and request types
`define RQ_GET_CONFIG       8'h08
`define RQ_SET_CONFIG       8'h09
`define RQ_GET_DESCRIPTOR   8'h06
`define RQ_GET_INTERFACE    8'h0a
`define RQ_SET_INTERFACE    8'h0b
`define RT_DEV_IN           8'h80
`define RT_DEV_OUT          8'h00
`define RT_IF_IN            8'h81
`define RT_IF_OUT           8'h01

`endif

//--- logic/descriptor_rom.v
`timescale 1ns/1ps
`include "descriptor_defines.vh"

// combinational lookup of one stored descriptor byte
module descriptor_rom #(
	parameter [15:0]  VENDOR_ID   = 16'h1234,
	parameter [15:0]  PRODUCT_ID  = 16'h5678,
	parameter [15:0]  RELEASE_BCD = 16'h0000,
	parameter [239:0] EP_BODY     = 240'h0
) (
	input  wire [1:0] kind_i,
	input  wire [7:0] idx_i,
	output reg  [7:0] byte_o
);

	integer ep_num;
	integer ep_byte;
	reg     [7:0] rel;

	// pick the byte by descriptor and offset
	always @* begin
		ep_num  = 0;
		ep_byte = 0;
		rel     = 8'h00;
		byte_o  = 8'h00;
		case (kind_i)
		`KIND_DEVICE: begin
			case (idx_i)
			8'd0:    byte_o = `LEN_DEVICE;
			8'd1:    byte_o = `DT_DEVICE;
			8'd2:    byte_o = `SPEC_REL_LO;
			8'd3:    byte_o = `SPEC_REL_HI;
			8'd4,
			8'd5,
			8'd6:    byte_o = `CLASS_VENDOR;
			8'd7:    byte_o = `EP0_MAX_PKT;
			8'd8:    byte_o = VENDOR_ID[7:0];
			8'd9:    byte_o = VENDOR_ID[15:8];
			8'd10:   byte_o = PRODUCT_ID[7:0];
			8'd11:   byte_o = PRODUCT_ID[15:8];
			8'd12:   byte_o = RELEASE_BCD[7:0];
			8'd13:   byte_o = RELEASE_BCD[15:8];
			8'd14,
			8'd15,
			8'd16:   byte_o = `NO_STRING;
			8'd17:   byte_o = `NUM_CONFIGS;
			default: byte_o = 8'h00;
			endcase
		end
		`KIND_QUALIFIER: begin
			case (idx_i)
			8'd0:    byte_o = `LEN_QUALIFIER;
			8'd1:    byte_o = `DT_QUALIFIER;
			8'd2:    byte_o = `SPEC_REL_LO;
			8'd3:    byte_o = `SPEC_REL_HI;
			8'd4,
			8'd5,
			8'd6:    byte_o = `CLASS_VENDOR;
			8'd7:    byte_o = `EP0_MAX_PKT;
			8'd8:    byte_o = `NUM_CONFIGS;
			8'd9:    byte_o = `QUAL_RESERVED;
			default: byte_o = 8'h00;
			endcase
		end
		`KIND_CONFIG: begin
			if (idx_i < `CFG_ALT0_BASE) begin
				case (idx_i)
				8'd0:    byte_o = `LEN_CONFIG;
				8'd1:    byte_o = `DT_CONFIG;
				8'd2:    byte_o = `CFG_TOTAL_LO;
				8'd3:    byte_o = `CFG_TOTAL_HI;
				8'd4:    byte_o = `CFG_NUM_IFACES;
				8'd5:    byte_o = `CFG_VALUE;
				8'd6:    byte_o = `NO_STRING;
				8'd7:    byte_o = `CFG_ATTR_BUS_PWR;
				8'd8:    byte_o = `CFG_MAX_POWER;
				default: byte_o = 8'h00;
				endcase
			end else if (idx_i < `CFG_EP_BASE) begin
				// both interface descriptors share one layout
				rel = (idx_i < `CFG_ALT1_BASE) ? idx_i - `CFG_ALT0_BASE : idx_i - `CFG_ALT1_BASE;
				case (rel)
				8'd0:    byte_o = `LEN_INTERFACE;
				8'd1:    byte_o = `DT_INTERFACE;
				8'd2:    byte_o = `IFACE_NUMBER;
				8'd3:    byte_o = (idx_i < `CFG_ALT1_BASE) ? `ALT0_SETTING : `ALT1_SETTING;
				8'd4:    byte_o = (idx_i < `CFG_ALT1_BASE) ? `ALT0_NUM_EP : `ALT1_NUM_EP;
				8'd5,
				8'd6,
				8'd7:    byte_o = `CLASS_VENDOR;
				8'd8:    byte_o = `NO_STRING;
				default: byte_o = 8'h00;
				endcase
			end else if (idx_i < `CFG_STORED_LEN) begin
				// endpoint descriptors of the second setting
				ep_num  = (idx_i - `CFG_EP_BASE) / 7;
				ep_byte = (idx_i - `CFG_EP_BASE) % 7;
				if (ep_byte == 0) begin
					byte_o = `LEN_ENDPOINT;
				end else if (ep_byte == 1) begin
					byte_o = `DT_ENDPOINT;
				end else begin
					byte_o = EP_BODY[(ep_num * 5 + ep_byte - 2) * 8 +: 8];
				end
			end
		end
		default: byte_o = 8'h00;
		endcase
	end

endmodule
